// ---- hw/stf_tx_fifo.sv ----
/*
 * Transmit entry FIFO with per-entry select, transfer-end and frame-end control.
 * Assumes an APB master on clk_sys and serial transmit logic on the same clock.
 */
`timescale 1ns/100ps
`include "stf_consts.svh"
// What this block does
// - Low sixteen bits carry outgoing payload
// - Per-entry select bit zero asserts that line
// - Pin polarity from configuration, default active low
// - Transfer end deasserts select, holds transfer gap
// - No transfer end keeps select asserted
// - Frame end inserts frame gap before next
// - No frame end inserts no frame gap
// - Word, low half, high half write kinds
// - Held control applied to payload-only writes
// - Length code n means n plus one bits
module stf_tx_fifo #(
    parameter int DEPTH = 8,
    parameter int AW    = 3
) (
    // Clock, reset, enable
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    input  wire logic        clk_en,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [15:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // Serial transmit side
    output logic             tx_valid,
    input  wire logic        tx_ready,
    input  wire logic        tx_shift_done,
    output logic [15:0]      transmit_payload,
    output logic [3:0]       bit_count_field,
    output logic             tx_rx_ignore,
    output logic             transfer_end_flag,
    output logic             tx_frame_end,
    // Select pins
    output logic [3:0]       peripheral_select
);

    typedef struct packed {
        stf_pkg::stf_entry_t [DEPTH-1:0] mem;
        logic [AW-1:0]       wp;
        logic [AW-1:0]       rp;
        logic [AW:0]         level;
        logic [11:0]         held_ctrl;
        logic [3:0]          sel_pol;
        logic [15:0]         xfer_gap;
        logic [15:0]         frame_gap;
        stf_pkg::stf_state_t st;
        logic [16:0]         gap_cnt;
        logic [3:0]          sel_act;
        logic                pready;
        logic [31:0]         prdata;
        logic                pslverr;
        logic                tx_valid;
        stf_pkg::stf_entry_t out;
        logic [3:0]          pins;
    } stf_regs_t;

    stf_regs_t q_r;
    stf_regs_t q_nxt;

    logic          acc;
    logic          full;
    logic          do_push;
    logic          do_pop;
    logic [11:0]   wctrl;
    logic [16:0]   gap;

    // Bus decode, FIFO, sequencer and pin levels
    always_comb begin
        q_nxt   = q_r;
        do_push = 1'b0;
        do_pop  = 1'b0;
        gap     = 17'h00000;
        wctrl   = q_r.held_ctrl;
        full    = (q_r.level == (AW+1)'(DEPTH));
        acc     = psel && penable && !q_r.pready;
        q_nxt.pready  = 1'b0;
        q_nxt.pslverr = 1'b0;
        q_nxt.prdata  = 32'h00000000;
        if (acc) begin
            case (paddr)
                `STF_OFS_DATCTL: begin
                    if (!pwrite) begin
                        q_nxt.pready = 1'b1; // Write-only, reads zero
                    end else if (pstrb == `STF_STRB_HIGH) begin
                        q_nxt.held_ctrl = pwdata[`STF_CTRL_MSB:`STF_CTRL_LSB];
                        q_nxt.pready    = 1'b1;
                    end else if (pstrb == `STF_STRB_WORD || pstrb == `STF_STRB_LOW) begin
                        // Stall the bus while the FIFO is full
                        if (!full) begin
                            if (pstrb == `STF_STRB_WORD) begin
                                wctrl = pwdata[`STF_CTRL_MSB:`STF_CTRL_LSB];
                            end
                            q_nxt.held_ctrl = wctrl;
                            q_nxt.mem[q_r.wp] = {wctrl, pwdata[`STF_PAYLOAD_MSB:0]};
                            do_push      = 1'b1;
                            q_nxt.pready = 1'b1;
                        end
                    end else begin
                        q_nxt.pready  = 1'b1;
                        q_nxt.pslverr = 1'b1;
                    end
                end
                `STF_OFS_CFG: begin
                    q_nxt.pready = 1'b1;
                    if (pwrite) begin
                        q_nxt.sel_pol = pwdata[3:0];
                    end else begin
                        q_nxt.prdata = {28'h0000000, q_r.sel_pol};
                    end
                end
                `STF_OFS_GAP: begin
                    q_nxt.pready = 1'b1;
                    if (pwrite) begin
                        q_nxt.xfer_gap  = pwdata[15:0];
                        q_nxt.frame_gap = pwdata[31:16];
                    end else begin
                        q_nxt.prdata = {q_r.frame_gap, q_r.xfer_gap};
                    end
                end
                `STF_OFS_STAT: begin
                    q_nxt.pready  = 1'b1;
                    q_nxt.pslverr = pwrite;
                    q_nxt.prdata  = {24'h000000, 2'(q_r.st), 1'b0, full,
                                     (q_r.level == '0), 3'(q_r.level)};
                end
                default: begin
                    q_nxt.pready  = 1'b1;
                    q_nxt.pslverr = 1'b1;
                end
            endcase
        end

        // Transmit sequencer
        case (q_r.st)
            stf_pkg::STF_IDLE: begin
                if (q_r.level != '0) begin
                    q_nxt.out      = q_r.mem[q_r.rp];
                    q_nxt.tx_valid = 1'b1;
                    q_nxt.sel_act  = ~q_r.mem[q_r.rp].ctrl[`STF_SEL_MSB:`STF_SEL_LSB];
                    do_pop         = 1'b1;
                    q_nxt.st       = stf_pkg::STF_OFFER;
                end
            end
            stf_pkg::STF_OFFER: begin
                if (tx_ready) begin
                    q_nxt.tx_valid = 1'b0;
                    q_nxt.st       = stf_pkg::STF_BUSY;
                end
            end
            stf_pkg::STF_BUSY: begin
                if (tx_shift_done) begin
                    if (q_r.out.ctrl[`STF_TEND_BIT]) begin
                        q_nxt.sel_act = 4'h0;
                        gap = {1'b0, q_r.xfer_gap};
                    end
                    // Without transfer end the select stays asserted
                    if (q_r.out.ctrl[`STF_EOF_BIT] && {1'b0, q_r.frame_gap} > gap) begin
                        gap = {1'b0, q_r.frame_gap};
                    end
                    q_nxt.gap_cnt = gap;
                    q_nxt.st = (gap == '0) ? stf_pkg::STF_IDLE : stf_pkg::STF_GAP;
                end
            end
            stf_pkg::STF_GAP: begin
                q_nxt.gap_cnt = q_r.gap_cnt - 17'h00001;
                if (q_r.gap_cnt == 17'h00001) begin
                    q_nxt.st = stf_pkg::STF_IDLE;
                end
            end
            default: q_nxt.st = stf_pkg::STF_IDLE;
        endcase

        // Pointers and fill level in write order
        if (do_push) begin
            q_nxt.wp = q_r.wp + AW'(1);
        end
        if (do_pop) begin
            q_nxt.rp = q_r.rp + AW'(1);
        end
        q_nxt.level = q_r.level + (AW+1)'(do_push) - (AW+1)'(do_pop);

        // Active state mapped to pin level by polarity
        q_nxt.pins = (q_nxt.sel_act & q_nxt.sel_pol) | (~q_nxt.sel_act & ~q_nxt.sel_pol);
    end

    // State register
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            q_r           <= '0;
            q_r.held_ctrl <= `STF_CTRL_RST;
            q_r.sel_pol   <= `STF_POL_RST;
            q_r.xfer_gap  <= `STF_GAP_RST;
            q_r.frame_gap <= `STF_GAP_RST;
            q_r.pins      <= ~`STF_POL_RST;
        end else if (clk_en) begin
            q_r <= q_nxt;
        end
    end

    // Outputs straight from state
    assign pready            = q_r.pready;
    assign prdata            = q_r.prdata;
    assign pslverr           = q_r.pslverr;
    assign tx_valid          = q_r.tx_valid;
    assign transmit_payload  = q_r.out.payload;
    assign bit_count_field   = q_r.out.ctrl[`STF_BCNT_MSB:`STF_BCNT_LSB];
    assign tx_rx_ignore      = q_r.out.ctrl[`STF_RXIGN_BIT];
    assign transfer_end_flag = q_r.out.ctrl[`STF_TEND_BIT];
    assign tx_frame_end      = q_r.out.ctrl[`STF_EOF_BIT];
    assign peripheral_select = q_r.pins;

endmodule

// ---- include/stf_consts.svh ----
/*
 * Offsets, field positions, byte-lane patterns and reset values of the SPI transmit entry block.
 * Assumes inclusion by bare name from design files.
 */
`ifndef STF_CONSTS_SVH
`define STF_CONSTS_SVH

// Register byte offsets
`define STF_OFS_CFG        16'h2000
`define STF_OFS_GAP        16'h2004
`define STF_OFS_STAT       16'h2008
`define STF_OFS_DATCTL     16'h2018

// Entry word fields
`define STF_PAYLOAD_MSB    15
`define STF_CTRL_LSB       16
`define STF_CTRL_MSB       27
`define STF_SEL_LSB        0
`define STF_SEL_MSB        3
`define STF_TEND_BIT       4
`define STF_EOF_BIT        5
`define STF_RXIGN_BIT      6
`define STF_BCNT_LSB       8
`define STF_BCNT_MSB       11

// Byte-lane patterns
`define STF_STRB_WORD      4'hF
`define STF_STRB_LOW       4'h3
`define STF_STRB_HIGH      4'hC

// Reset values
`define STF_CTRL_RST       12'h00F
`define STF_POL_RST        4'h0
`define STF_GAP_RST        16'h0000

`endif

// ---- include/stf_pkg.sv ----
/*
 * Types of the SPI transmit entry block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package stf_pkg;

    // Sequencer states, Gray along idle, offer, busy, gap
    typedef enum logic [1:0] {
        STF_IDLE  = 2'b00,
        STF_OFFER = 2'b01,
        STF_BUSY  = 2'b11,
        STF_GAP   = 2'b10
    } stf_state_t;

    // One queued entry: control bits over payload
    typedef struct packed {
        logic [11:0] ctrl;
        logic [15:0] payload;
    } stf_entry_t;

endpackage

// ---- tb/stf_serial_model.sv ----
/* Behavioural serial transmit logic facing the entry block.
   Assumes the block's clock; slow adds three bit times per entry. */
`timescale 1ns/100ps
module stf_serial_model (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       reset_n,
    // Entry handshake
    input  wire logic       tx_valid,
    input  wire logic [3:0] bit_count_field,
    input  wire logic       slow,
    output logic            tx_ready,
    output logic            tx_shift_done
);
    int   cnt;
    logic busy;
    // Accept one offer, shift n plus one bits, then report done
    always_ff @(posedge clk_sys) begin
        tx_shift_done <= 1'b0;
        if (!reset_n) begin
            tx_ready <= 1'b0;
            busy     <= 1'b0;
        end else if (tx_ready) begin
            tx_ready <= 1'b0;
            busy     <= 1'b1;
            cnt      <= int'(bit_count_field) + (slow ? 3 : 0);
        end else if (busy) begin
            busy          <= cnt != 0;
            tx_shift_done <= cnt == 0;
            cnt           <= cnt - 1;
        end else if (tx_valid) begin
            tx_ready <= 1'b1;
        end
    end
endmodule

// ---- tb/stf_tx_fifo_props.sv ----
/* Checker for the transmit entry block.
   Assumes a bind to stf_tx_fifo and select polarity left at reset. */
`timescale 1ns/100ps
module stf_tx_fifo_props (
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        reset_n,
    // Watched ports
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    input wire logic        tx_valid,
    input wire logic        tx_ready,
    input wire logic        tx_shift_done,
    input wire logic        transfer_end_flag,
    input wire logic [15:0] transmit_payload,
    input wire logic [3:0]  bit_count_field,
    input wire logic [3:0]  peripheral_select
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    sequence offer_held; tx_valid && !tx_ready; endsequence
    sequence shift_end; tx_shift_done; endsequence
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    ready_bound_a: assert property (psel && penable && !pready |-> ##[1:100] pready)
        else $error("no APB answer");
    offer_hold_a: assert property (offer_held |=> tx_valid && $stable(transmit_payload))
        else $error("offer changed before acceptance");
    offer_drop_a: assert property (tx_valid && tx_ready |=> !tx_valid)
        else $error("offer stayed after acceptance");
    sel_keep_a: assert property (shift_end ##0 !transfer_end_flag |=> $stable(peripheral_select))
        else $error("select moved without transfer end");
    sel_release_a: assert property (shift_end ##0 transfer_end_flag |=> peripheral_select == 4'hF)
        else $error("select not released at transfer end");
    no_early_a: assert property (shift_end |=> !tx_valid)
        else $error("offer right after shift end");
    len_hold_a: assert property (tx_valid && !$rose(tx_valid) |-> $stable(bit_count_field))
        else $error("length changed during offer");
endmodule

// ---- tb/tb_top.sv ----
/* Self-checking bench for the transmit entry block.
   Assumes stf_serial_model on the serial side; gaps set to 5 and 9 cycles. */
`timescale 1ns/100ps
`include "stf_consts.svh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin errors++; \
    $display("CHECK FAILED at %0t: got %h want %h", $time, a, b); end end
module tb_top;
    logic clk_sys, reset_n, psel, penable, pwrite, pready, pslverr, tx_valid, tx_ready;
    logic tx_shift_done, tx_rx_ignore, transfer_end_flag, tx_frame_end, slow, err, chk_gap;
    logic [15:0] paddr, transmit_payload;
    logic [31:0] pwdata, prdata, rd, d;
    logic [3:0]  pstrb, bit_count_field, peripheral_select;
    logic [27:0] q[$];
    logic [27:0] e;
    logic [11:0] held;
    int          errors, n_checks, cyc, gap, exp_gap, i, seed = 59;
    stf_tx_fifo stf_tx_fifo_i (.clk_sys, .reset_n, .clk_en(1'b1), .psel, .penable, .pwrite,
        .paddr, .pwdata, .pstrb, .pready, .prdata, .pslverr, .tx_valid, .tx_ready,
        .tx_shift_done, .transmit_payload, .bit_count_field, .tx_rx_ignore,
        .transfer_end_flag, .tx_frame_end, .peripheral_select);
    stf_serial_model stf_serial_model_i (.clk_sys, .reset_n, .tx_valid, .bit_count_field,
        .slow, .tx_ready, .tx_shift_done);
    // Clock
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    task automatic test_done();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // One APB transfer, then one idle cycle
    task automatic apb(input logic [15:0] a, input logic [31:0] dw, input logic [3:0] s,
                       input logic w);
        psel <= 1'b1; penable <= 1'b0; paddr <= a; pwdata <= dw; pstrb <= s; pwrite <= w;
        @(posedge clk_sys) penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge clk_sys);
    endtask
    // Entry write plus model update
    task automatic put(input logic [31:0] dw, input logic [3:0] s);
        apb(`STF_OFS_DATCTL, dw, s, 1'b1);
        `CHK(err, 1'b0)
        if (s != `STF_STRB_LOW) held = dw[27:16];
        if (s != `STF_STRB_HIGH) q.push_back({held, dw[15:0]});
    endtask
    // Timeout, gap count and entry compare at each acceptance
    always @(posedge clk_sys) begin
        cyc++;
        gap++;
        if (tx_shift_done) begin gap = 0; chk_gap = q.size() > 0; end
        if (reset_n && tx_valid && tx_ready) begin
            `CHK(q.size() > 0, 1'b1)
            e = q.pop_front();
            `CHK(transmit_payload, e[15:0])
            `CHK(peripheral_select, e[19:16])
            `CHK({tx_frame_end, transfer_end_flag}, e[21:20])
            `CHK({tx_rx_ignore, bit_count_field}, {e[22], e[27:24]})
            if (chk_gap) `CHK(gap, exp_gap + 3)
            exp_gap = e[21] ? 9 : (e[20] ? 5 : 0);
            chk_gap = 1'b0;
        end
        // Timeout ends the run as a failure
        if (cyc > 5000) begin errors++; test_done(); end
    end
    // Main sequence
    initial begin
        psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; pstrb = 0; slow = 0;
        reset_n = 0; held = 12'h00F; chk_gap = 0; errors = 0; n_checks = 0; cyc = 0;
        repeat (2) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        `CHK(peripheral_select, 4'hF)
        apb(`STF_OFS_GAP, 32'h0009_0005, `STF_STRB_WORD, 1'b1);
        for (i = 0; i < 16; i++) begin
            slow <= 1'($random(seed));
            d = $random(seed);
            d[31:16] = {4'h0, 4'(i), 1'b0, 3'(i), d[19:16]};
            put(d, `STF_STRB_WORD);
        end
        $display("word entries done");
        // Two-entry frame, only the last marked frame end
        put(32'h0F0E_AAAA, `STF_STRB_WORD);
        put(32'h0F3E_5555, `STF_STRB_WORD);
        put(32'h0F33_0000, `STF_STRB_HIGH);
        for (i = 0; i < 3; i++) put($random(seed), `STF_STRB_LOW);
        $display("half entries done");
        apb(`STF_OFS_DATCTL, 32'h0F00_1234, 4'h1, 1'b1);
        `CHK(err, 1'b1)
        apb(16'h2100, 32'h0, `STF_STRB_WORD, 1'b1);
        `CHK(err, 1'b1)
        apb(`STF_OFS_DATCTL, 32'h0, `STF_STRB_WORD, 1'b0);
        `CHK({err, rd}, 33'h0)
        $display("refusals done");
        while (q.size() > 0 || tx_valid) @(posedge clk_sys);
        repeat (40) @(posedge clk_sys);
        // Readback of gaps, idle status and select polarity
        apb(`STF_OFS_GAP, 32'h0, `STF_STRB_WORD, 1'b0);
        `CHK(rd, 32'h0009_0005)
        apb(`STF_OFS_STAT, 32'h0, `STF_STRB_WORD, 1'b0);
        `CHK(rd, 32'h0000_0008)
        apb(`STF_OFS_CFG, 32'h5, `STF_STRB_WORD, 1'b1);
        `CHK(peripheral_select, 4'hA)
        apb(`STF_OFS_CFG, 32'h0, `STF_STRB_WORD, 1'b0);
        `CHK(rd, 32'h0000_0005)
        apb(`STF_OFS_CFG, 32'h0, `STF_STRB_WORD, 1'b1);
        `CHK(peripheral_select, 4'hF)
        $display("configuration done");
        test_done();
    end
endmodule
bind stf_tx_fifo stf_tx_fifo_props stf_tx_fifo_props_i (.clk_sys(clk_sys), .reset_n(reset_n),
    .psel(psel), .penable(penable), .pready(pready), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_shift_done(tx_shift_done), .transfer_end_flag(transfer_end_flag),
    .transmit_payload(transmit_payload), .bit_count_field(bit_count_field),
    .peripheral_select(peripheral_select));
